// [hdl/nvsm_pkg.sv]
// Shared constants, state codes and helpers of the setting store
package nvsm_pkg;

   // Store layout: four switch bits and one held bit
   localparam int STORE_W  = 5;
   localparam int MUX_W    = 4;
   localparam int HELD_BIT = 4;
   localparam int BYTE_W   = 8;
   localparam int ADDR_W   = 7;
   localparam int CNT_W    = 3;
   localparam int PIN_W    = 9;

   // Value of the store before any bus write
   localparam logic [4:0] STORE_RST = 5'h00;

   // Own slave address; the value is arbitrary
   localparam logic [6:0] OWN_ADDR = 7'h2a;

   // Bit counter values
   localparam logic [2:0] CNT_FIRST = 3'h1;
   localparam logic [2:0] CNT_ZERO  = 3'h0;
   localparam logic [2:0] CNT_LAST  = 3'h7;
   localparam logic [2:0] CNT_STEP  = 3'h1;

   // Direction bit value that asks for a read
   localparam logic RW_READ = 1'b1;

   // Reset value of the pin synchronisers (pulled-up pins, locked)
   localparam logic [8:0] PIN_RST = 9'h1ff;

   // Serial slave states, Gray coded along the usual path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_AACK = 3'h3,
      ST_DATA = 3'h2,
      ST_DACK = 3'h6,
      ST_SKIP = 3'h7
   } nvsm_state_t;

   // A data byte is legal when its three top bits are zero
   function automatic logic nvsm_byte_ok(input logic [7:0] b);
      return ~|b[7:5];
   endfunction : nvsm_byte_ok

   // Place the stored setting in a data byte
   function automatic logic [7:0] nvsm_pack(input logic [4:0] s);
      return {3'h0, s};
   endfunction : nvsm_pack

endpackage : nvsm_pkg

// [hdl/nvsm_xfer_if.sv]
// Signals between the serial front end and the store unit
`timescale 1ns/1ns
interface nvsm_xfer_if;
   logic       commit;
   logic       wr_allow;
   logic [4:0] wr_data;
   logic       pick;
   logic       force_n;
   logic [3:0] sw_in;
   logic [4:0] stored;
   logic [3:0] sw_out;
   logic       held;

   modport ctl  (output commit, wr_allow, wr_data, pick, force_n, sw_in,
                 input  stored, sw_out, held);
   modport unit (input  commit, wr_allow, wr_data, pick, force_n, sw_in,
                 output stored, sw_out, held);
endinterface : nvsm_xfer_if

// [hdl/nvsm_store.sv]
// Setting store, output multiplexer and held-bit latch
`timescale 1ns/1ns
module nvsm_store (
   input logic          clk_i,
   input logic          nrst_i,
   nvsm_xfer_if.unit    ifc
);

   // Kept outside reset: the setting must survive a power-on reset
   logic [4:0] store_r = nvsm_pkg::STORE_RST;
   logic [3:0] out_r;
   logic       held_r;

   // Update only on a permitted commit; refused writes leave it alone
   always_ff @(posedge clk_i) begin
      if (ifc.commit && ifc.wr_allow) begin
         store_r <= ifc.wr_data;
      end
   end

   // Switch outputs: stored bits, external bits, or forced low
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_r <= nvsm_pkg::STORE_RST[3:0];
      end else if (ifc.pick) begin
         out_r <= ifc.sw_in;
      end else if (!ifc.force_n) begin
         out_r <= 4'h0;
      end else begin
         out_r <= store_r[3:0];
      end
   end

   // Held bit is transparent while pick is low and freezes on its rise,
   // so it keeps what it last showed, including a forced zero
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         held_r <= 1'b0;
      end else if (!ifc.pick) begin
         held_r <= ifc.force_n & store_r[nvsm_pkg::HELD_BIT];
      end
   end

   assign ifc.stored = store_r;
   assign ifc.sw_out = out_r;
   assign ifc.held   = held_r;

endmodule : nvsm_store

// [hdl/nvsm_top.sv]
// Top of the five-bit setting store with its serial slave front end
`timescale 1ns/1ns
// Operation
// - Pick low: outputs show stored low bits
// - Pick high: outputs show external inputs
// - Held bit transparent at pick low, holds high
// - Held value equals output at pick rise
// - Force low with pick low zeroes outputs
// - Writes accepted only while lock is low
// - Store has five bits, four muxed, one held
// - Store starts as all zeros
// - Transfer opens with seven-bit address, direction
// - Exactly eight data bits follow address acknowledge
// - Read returns store; write stores unless locked
// - Byte: three zero bits, held, four muxed
// - Nonzero top three bits abandon the write
// - Low device or bus supply blocks writes
// - Reset initialises serial machine and volatile state
// - After reset outputs follow the selection rules
module nvsm_top #(
   parameter logic [6:0] SLAVE_ADDR = nvsm_pkg::OWN_ADDR
) (
   input  logic       clk_i,
   input  logic       nrst_i,
   input  logic       scl_i,
   input  logic       sda_i,
   output logic       sda_o,
   output logic       sda_oe_o,
   input  logic [3:0] switch_in_i,
   input  logic       source_pick_i,
   input  logic       force_low_n_i,
   input  logic       write_lock_i,
   input  logic       supply_ok_i,
   input  logic       bus_supply_ok_i,
   output logic [3:0] switch_out_o,
   output logic       held_out_o
);

   // ------------------------------------------------------------
   // Serial side, clocked by the bus clock
   // ------------------------------------------------------------

   nvsm_pkg::nvsm_state_t state_r;
   logic [2:0]            cnt_r;
   logic [7:0]            shift_r;
   logic                  rw_r;
   logic                  start_tg_r;
   logic                  start_seen_r;
   logic                  start_new;
   logic                  wr_tg_r;
   logic [4:0]            wr_data_r;
   logic [7:0]            tx_r;
   logic                  sda_r;
   logic                  sda_oe_r;
   logic [4:0]            rd_meta_r;
   logic [4:0]            rd_sync_r;

   // ------------------------------------------------------------
   // System side, clocked by clk_i
   // ------------------------------------------------------------

   logic [8:0]            pin_meta_r;
   logic [8:0]            pin_sync_r;
   logic                  wr_meta_r;
   logic                  wr_sync_r;
   logic                  wr_last_r;
   logic                  commit_r;

   nvsm_xfer_if           xfer ();

   // Start marker: data falls while the bus clock is high. The flop
   // runs on the data line itself; the start hold time before the
   // first clock fall gives the serial side a settled toggle.
   always_ff @(negedge sda_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_tg_r <= 1'b0;
      end else if (scl_i) begin
         start_tg_r <= ~start_tg_r;
      end
   end

   // A start seen at this rising edge makes this bit the first one
   assign start_new = start_tg_r ^ start_seen_r;

   // Remember which start has been taken
   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_seen_r <= 1'b0;
      end else begin
         start_seen_r <= start_tg_r;
      end
   end

   // Bit sequencer: address, acknowledge, data byte, acknowledge.
   // A repeated start always wins and restarts the address phase.
   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= nvsm_pkg::ST_IDLE;
         cnt_r   <= nvsm_pkg::CNT_ZERO;
         shift_r <= 8'h00;
         rw_r    <= 1'b0;
      end else if (start_new) begin
         state_r <= nvsm_pkg::ST_ADDR;
         cnt_r   <= nvsm_pkg::CNT_FIRST;
         shift_r <= {7'h00, sda_i};
      end else begin
         unique case (state_r)
            nvsm_pkg::ST_IDLE: begin
               cnt_r <= nvsm_pkg::CNT_ZERO;
            end
            nvsm_pkg::ST_ADDR: begin
               shift_r <= {shift_r[6:0], sda_i};
               cnt_r   <= cnt_r + nvsm_pkg::CNT_STEP;
               // Eighth bit is the direction; address sits in shift_r
               if (cnt_r == nvsm_pkg::CNT_LAST) begin
                  rw_r <= sda_i;
                  if (shift_r[6:0] == SLAVE_ADDR) begin
                     state_r <= nvsm_pkg::ST_AACK;
                  end else begin
                     state_r <= nvsm_pkg::ST_SKIP;
                  end
               end
            end
            nvsm_pkg::ST_AACK: begin
               state_r <= nvsm_pkg::ST_DATA;
               cnt_r   <= nvsm_pkg::CNT_ZERO;
            end
            nvsm_pkg::ST_DATA: begin
               shift_r <= {shift_r[6:0], sda_i};
               cnt_r   <= cnt_r + nvsm_pkg::CNT_STEP;
               if (cnt_r == nvsm_pkg::CNT_LAST) begin
                  state_r <= nvsm_pkg::ST_DACK;
               end
            end
            nvsm_pkg::ST_DACK: begin
               // One byte per transfer; the rest is ignored until start
               state_r <= nvsm_pkg::ST_SKIP;
            end
            nvsm_pkg::ST_SKIP: begin
               cnt_r <= nvsm_pkg::CNT_ZERO;
            end
            default: begin
               state_r <= nvsm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Hand a finished write to the system side. Data and toggle move
   // on the same edge; data then stays put for a whole transfer, far
   // longer than the toggle takes to cross.
   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_tg_r   <= 1'b0;
         wr_data_r <= nvsm_pkg::STORE_RST;
      end else if (!start_new && (state_r == nvsm_pkg::ST_DACK) &&
                   (rw_r != nvsm_pkg::RW_READ) &&
                   nvsm_pkg::nvsm_byte_ok(shift_r)) begin
         wr_tg_r   <= ~wr_tg_r;
         wr_data_r <= shift_r[4:0];
      end
   end

   // Stored value into the bus clock domain. The bus clock stops
   // between frames, but the address byte gives eight edges to settle.
   always_ff @(posedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_meta_r <= nvsm_pkg::STORE_RST;
         rd_sync_r <= nvsm_pkg::STORE_RST;
      end else begin
         rd_meta_r <= xfer.stored;
         rd_sync_r <= rd_meta_r;
      end
   end

   // Line driver, changed on the falling bus clock only. The pin is
   // open drain: the enable pulls low, sda_o stays zero.
   always_ff @(negedge scl_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sda_r    <= 1'b0;
         sda_oe_r <= 1'b0;
         tx_r     <= 8'h00;
      end else begin
         sda_r <= 1'b0;
         unique case (state_r)
            nvsm_pkg::ST_AACK: begin
               sda_oe_r <= 1'b1;
               tx_r     <= nvsm_pkg::nvsm_pack(rd_sync_r);
            end
            nvsm_pkg::ST_DATA: begin
               if (rw_r == nvsm_pkg::RW_READ) begin
                  sda_oe_r <= ~tx_r[7];
                  tx_r     <= {tx_r[6:0], 1'b0};
               end else begin
                  sda_oe_r <= 1'b0;
               end
            end
            nvsm_pkg::ST_DACK: begin
               // Ack a legal write byte; on a read the master answers
               sda_oe_r <= (rw_r != nvsm_pkg::RW_READ) &&
                           nvsm_pkg::nvsm_byte_ok(shift_r);
            end
            default: begin
               sda_oe_r <= 1'b0;
            end
         endcase
      end
   end

   assign sda_o    = sda_r;
   assign sda_oe_o = sda_oe_r;

   // Pin synchronisers, two flops each. Reset shows the pins at
   // their pulled-up level, which also keeps writes locked.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_meta_r <= nvsm_pkg::PIN_RST;
         pin_sync_r <= nvsm_pkg::PIN_RST;
      end else begin
         pin_meta_r <= {switch_in_i, source_pick_i, force_low_n_i,
                        write_lock_i, supply_ok_i, bus_supply_ok_i};
         pin_sync_r <= pin_meta_r;
      end
   end

   // Write toggle crossing and one-cycle commit pulse
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_meta_r <= 1'b0;
         wr_sync_r <= 1'b0;
         wr_last_r <= 1'b0;
         commit_r  <= 1'b0;
      end else begin
         wr_meta_r <= wr_tg_r;
         wr_sync_r <= wr_meta_r;
         wr_last_r <= wr_sync_r;
         commit_r  <= wr_sync_r ^ wr_last_r;
      end
   end

   // Permission is judged at commit time: lock low and both supplies up
   assign xfer.wr_allow = ~pin_sync_r[2] &
                          pin_sync_r[1] & pin_sync_r[0];
   assign xfer.commit   = commit_r;
   assign xfer.wr_data  = wr_data_r;
   assign xfer.sw_in    = pin_sync_r[8:5];
   assign xfer.pick     = pin_sync_r[4];
   assign xfer.force_n  = pin_sync_r[3];

   // Store, selection and held latch
   nvsm_store u_store (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .ifc    (xfer.unit)
   );

   assign switch_out_o = xfer.sw_out;
   assign held_out_o   = xfer.held;

endmodule : nvsm_top

// [test/nvsm_checker.sv]
// Port-level concurrent checks of the setting store top
`timescale 1ns/1ns
module nvsm_checker (
   input logic       clk_i,
   input logic       nrst_i,
   input logic       scl_i,
   input logic       sda_o,
   input logic       sda_oe_o,
   input logic [3:0] switch_in_i,
   input logic       source_pick_i,
   input logic       force_low_n_i,
   input logic       write_lock_i,
   input logic       supply_ok_i,
   input logic       bus_supply_ok_i,
   input logic [3:0] switch_out_o,
   input logic       held_out_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Any one of these must block a store write
   logic blk;
   assign blk = write_lock_i | ~supply_ok_i | ~bus_supply_ok_i;
   // Pins cross two sync flops and an output flop, hence the repeats
   property p_quiet;
      disable iff (1'h0) !nrst_i |-> !{switch_out_o, held_out_o, sda_oe_o};
   endproperty
   a_quiet: assert property (p_quiet) else $error("quiet");
   property p_mux;
      (source_pick_i && $stable(switch_in_i))[*4]
         |-> switch_out_o == switch_in_i;
   endproperty
   a_mux: assert property (p_mux) else $error("mux");
   property p_force;
      (!force_low_n_i && !source_pick_i)[*4] |-> switch_out_o == 4'h0;
   endproperty
   a_force: assert property (p_force) else $error("force");
   property p_fheld;
      (!force_low_n_i && !source_pick_i)[*4] |-> !held_out_o;
   endproperty
   a_fheld: assert property (p_fheld) else $error("fheld");
   property p_hold;
      source_pick_i[*5] |-> $stable(held_out_o);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   // Outputs cannot move while pick is low, force is high and every write is blocked
   property p_lock;
      (!source_pick_i && force_low_n_i && blk)[*5]
         |-> $stable({switch_out_o, held_out_o});
   endproperty
   a_lock: assert property (p_lock) else $error("lock");
   property p_oe;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_low;
      sda_oe_o |-> !sda_o;
   endproperty
   a_low: assert property (p_low) else $error("low");
endmodule : nvsm_checker
bind nvsm_top nvsm_checker chk (
   .clk_i, .nrst_i, .scl_i, .sda_o, .sda_oe_o, .switch_in_i, .source_pick_i,
   .force_low_n_i, .write_lock_i, .supply_ok_i, .bus_supply_ok_i,
   .switch_out_o, .held_out_o
);

// [test/nvsm_bus_master.sv]
// Behavioural serial bus master facing the setting store
`timescale 1ns/1ns
module nvsm_bus_master (
   input  logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   // Clock stands high and data is released between frames
   initial begin
      scl_o = 1'h1;
      sda_oe_o = 1'h0;
   end
   // Data moves mid-low and is read mid-high, 125 ns a bit
   task automatic bit_io(input logic b, output logic r);
      #31 sda_oe_o = ~b;
      #31 scl_o = 1'h1;
      #31 r = sda_i;
      #32 scl_o = 1'h0;
   endtask : bit_io
   // Eight bits MSB first, then a released acknowledge slot
   task automatic byte_io(input logic [7:0] b, output logic [7:0] r,
                          output logic ak);
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r[i]);
      bit_io(1'h1, ak);
      ak = ~ak;
   endtask : byte_io
   // Start, address byte, one data byte, stop; reads end in a nack
   task automatic xfer(input logic [6:0] a, input logic rw,
                       input logic [7:0] d, output logic [1:0] ak,
                       output logic [7:0] rd);
      logic [7:0] dummy;
      #31 sda_oe_o = 1'h1;
      #31 scl_o = 1'h0;
      byte_io({a, rw}, dummy, ak[1]);
      byte_io(rw ? 8'hff : d, rd, ak[0]);
      #31 sda_oe_o = 1'h1;
      #31 scl_o = 1'h1;
      #31 sda_oe_o = 1'h0;
   endtask : xfer
endmodule : nvsm_bus_master

// [test/nvsm_top_tb.sv]
// Self-checking bench of the setting store and its serial front end
`timescale 1ns/1ns
`define CHK(G, E) begin qe.push_back(E); qg.push_back(G); end
module nvsm_top_tb;
   logic clk_i = 1'h0, nrst_i = 1'h1, pick = 1'h1, force_n = 1'h1;
   logic lock = 1'h0, sup = 1'h1, bsup = 1'h1, scl, m_oe, dut_oe, sda;
   logic held, h;
   logic [3:0] sw_in = 4'h0, sw_out;
   logic [4:0] st;
   logic [1:0] ak;
   logic [7:0] rd, g, e, qe[$], qg[$];
   int miscompares, n_checks, cyc;
   // Pulled-up data line, low while either side pulls
   assign sda = ~(m_oe | dut_oe);
   nvsm_bus_master m (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
   nvsm_top dut (
      .clk_i, .nrst_i, .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_o(dut_oe), .switch_in_i(sw_in), .source_pick_i(pick),
      .force_low_n_i(force_n), .write_lock_i(lock), .supply_ok_i(sup),
      .bus_supply_ok_i(bsup), .switch_out_o(sw_out), .held_out_o(held)
   );
   // 20 MHz system clock
   initial forever #25 clk_i = ~clk_i;
   // Compare each observed value with the oldest note
   initial forever begin
      wait (qg.size() != 0);
      g = qg.pop_front();
      e = qe.pop_front();
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   end
   // A hang ends the run as a failure
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic summarize;
      #1;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wt
   // Store commits a few cycles after the frame, so settle before looking
   task automatic xf(input logic rw, input logic [7:0] d,
                     input logic [6:0] a = nvsm_pkg::OWN_ADDR);
      m.xfer(a, rw, d, ak, rd);
      wt(8);
   endtask : xf
   function automatic logic [7:0] outs();
      return {3'h0, held, sw_out};
   endfunction : outs
   // Main sequence; after reset falls, every pin change outside a transfer lands on a falling edge
   initial begin
      void'($urandom(28));
      sw_in = 4'($urandom);
      // Reset falls after time zero so every async reset branch sees it
      #1 nrst_i = 1'h0;
      wt(4);
      `CHK(outs(), 8'h00)
      nrst_i = 1'h1;
      pick = 1'h0;
      wt(5);
      `CHK(outs(), 8'h00)
      xf(1'h1, 8'h00);
      `CHK({6'h0, ak}, 8'h02)
      `CHK(rd, 8'h00)
      $display("test factory done");
      repeat (4) begin
         st = 5'($urandom);
         xf(1'h0, {3'h0, st});
         `CHK({6'h0, ak}, 8'h03)
         `CHK(outs(), {3'h0, st})
         xf(1'h1, 8'h00);
         `CHK(rd, {3'h0, st})
      end
      $display("test write done");
      // Held bit freezes at the rise even though the store changes
      h = st[4];
      pick = 1'h1;
      st[4] = ~h;
      xf(1'h0, {3'h0, st});
      repeat (3) begin
         sw_in = 4'($urandom);
         force_n = 1'($urandom);
         wt(4);
         `CHK(outs(), {3'h0, h, sw_in})
      end
      force_n = 1'h1;
      pick = 1'h0;
      wt(4);
      `CHK(outs(), {3'h0, st})
      force_n = 1'h0;
      wt(4);
      `CHK(outs(), 8'h00)
      force_n = 1'h1;
      $display("test mux done");
      // Lock, device supply and bus supply each block the write
      for (int i = 0; i < 3; i++) begin
         {lock, sup, bsup} = (3'h4 >> i) ^ 3'h3;
         wt(4);
         xf(1'h0, {3'h0, ~st});
         `CHK(outs(), {3'h0, st})
         `CHK({6'h0, ak}, 8'h03)
      end
      {lock, sup, bsup} = 3'h3;
      for (int i = 5; i < 8; i++) begin
         xf(1'h0, 8'h01 << i | {3'h0, ~st});
         `CHK({6'h0, ak}, 8'h02)
         `CHK(outs(), {3'h0, st})
      end
      xf(1'h0, {3'h0, ~st}, nvsm_pkg::OWN_ADDR ^ 7'h01);
      `CHK({6'h0, ak}, 8'h00)
      `CHK(outs(), {3'h0, st})
      $display("test refused done");
      // The store survives a second reset
      nrst_i = 1'h0;
      wt(2);
      nrst_i = 1'h1;
      wt(4);
      `CHK(outs(), {3'h0, st})
      $display("test reset done");
      summarize();
   end
endmodule : nvsm_top_tb
